// ### design/fdm_pkg.sv
package fdm_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_TRIG_CFG  = 8'h04;
    localparam logic [7:0] ADDR_TORCH_LVL = 8'h08;
    localparam logic [7:0] ADDR_FLASH_LVL = 8'h0C;
    localparam logic [7:0] ADDR_STATUS    = 8'h10;
    localparam logic [7:0] ADDR_SER_TX    = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_BOOST_EN   = 0;
    localparam int CTRL_BOOST_MODE = 1;
    localparam int CTRL_TORCH      = 4;
    localparam int CTRL_FLASH      = 6;
    localparam int TRIG_A_FN       = 0;
    localparam int TRIG_B_FN       = 2;
    localparam int STAT_MODE       = 0;
    localparam int STAT_VIN_OK     = 3;
    localparam int STAT_VDD_OK     = 4;
    localparam int STAT_RX_BYTE    = 8;
    localparam int SER_DRIVE       = 8;

    // ------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------
    localparam logic [31:0] RST_REG   = 32'h0000_0000;
    localparam logic [1:0]  TRIG_NONE  = 2'h0;
    localparam logic [1:0]  TRIG_TORCH = 2'h1;
    localparam logic [1:0]  TRIG_FLASH = 2'h2;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam int          SYNC_STAGES = 2;

    typedef enum logic [2:0] {
        FDM_SHUTDOWN = 3'b000,
        FDM_STANDBY  = 3'b001,
        FDM_ACTIVE   = 3'b010,
        FDM_TORCH    = 3'b011,
        FDM_FLASH    = 3'b100
    } fdm_mode_t;

endpackage

// ### design/fdm_sync.sv
`timescale 1ns/1ps
module fdm_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    // The first stage is read by the second stage only.
    logic [WIDTH-1:0] meta;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            meta   <= '0;
            sync_o <= '0;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule

// ### design/fdm_mode_ctrl.sv
`timescale 1ns/1ps
module fdm_mode_ctrl (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    // AXI4-Lite register port
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Pins to and from outside the clock domain
    input  wire logic        logic_supply_ok_i,
    input  wire logic        input_supply_ok_i,
    input  wire logic        trigger_input_a_i,
    input  wire logic        trigger_input_b_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    // Power stage controls
    output logic [2:0]       mode_o,
    output logic             boost_en_o,
    output logic [1:0]       boost_mode_select_o,
    output logic             led_output_one_en_o,
    output logic             led_output_two_en_o,
    output logic             led_output_one_flash_o,
    output logic             led_output_two_flash_o,
    output logic [7:0]       led_output_one_level_o,
    output logic [7:0]       led_output_two_level_o
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [5:0] pins_s;

    fdm_sync #(
        .WIDTH (6)
    ) u_sync (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .async_i ({scl_i, sda_i, logic_supply_ok_i, input_supply_ok_i,
                   trigger_input_b_i, trigger_input_a_i}),
        .sync_o  (pins_s)
    );

    wire scl_s  = pins_s[5];
    wire sda_s  = pins_s[4];
    wire vdd_ok = pins_s[3];
    wire vin_ok = pins_s[2];
    wire trig_b = pins_s[1];
    wire trig_a = pins_s[0];

    // Logic supply loss clears all software state.
    wire regs_clr = !rst_n_i || !vdd_ok;

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0]  ctrl;
    logic [3:0]  trig_cfg;
    logic [15:0] torch_lvl;
    logic [15:0] flash_lvl;
    logic [8:0]  ser_tx;
    logic [7:0]  rx_byte;
    fdm_pkg::fdm_mode_t mode;

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    logic        aw_full;
    logic        w_full;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready  = !w_full && !s_axi_bvalid;

    wire aw_take  = s_axi_awvalid && s_axi_awready;
    wire w_take   = s_axi_wvalid && s_axi_wready;
    wire wr_fire  = aw_full && w_full && !s_axi_bvalid;
    wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                         {8{w_strb[1]}}, {8{w_strb[0]}}};

    wire wr_ctrl  = wr_fire && (aw_addr == fdm_pkg::ADDR_CTRL);
    wire wr_trig  = wr_fire && (aw_addr == fdm_pkg::ADDR_TRIG_CFG);
    wire wr_torch = wr_fire && (aw_addr == fdm_pkg::ADDR_TORCH_LVL);
    wire wr_flash = wr_fire && (aw_addr == fdm_pkg::ADDR_FLASH_LVL);
    wire wr_ser   = wr_fire && (aw_addr == fdm_pkg::ADDR_SER_TX);
    wire wr_stat  = wr_fire && (aw_addr == fdm_pkg::ADDR_STATUS);
    wire wr_hit   = wr_ctrl || wr_trig || wr_torch || wr_flash || wr_ser || wr_stat;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [31:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    wire [31:0] next_ctrl  = merge({24'h00_0000, ctrl}, w_data, wmask);
    wire [31:0] next_trig  = merge({28'h000_0000, trig_cfg}, w_data, wmask);
    wire [31:0] next_torch = merge({16'h0000, torch_lvl}, w_data, wmask);
    wire [31:0] next_flash = merge({16'h0000, flash_lvl}, w_data, wmask);
    wire [31:0] next_ser   = merge({23'h00_0000, ser_tx}, w_data, wmask);

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            aw_full      <= 1'b0;
            w_full       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= fdm_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_full      <= 1'b0;
                w_full       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? fdm_pkg::RESP_OKAY : fdm_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Writes while the logic supply is low are answered but have no effect.
    always_ff @(posedge mclk_i) begin
        if (regs_clr) begin
            ctrl      <= fdm_pkg::RST_REG[7:0];
            trig_cfg  <= fdm_pkg::RST_REG[3:0];
            torch_lvl <= fdm_pkg::RST_REG[15:0];
            flash_lvl <= fdm_pkg::RST_REG[15:0];
            ser_tx    <= fdm_pkg::RST_REG[8:0];
        end else begin
            if (wr_ctrl) begin
                ctrl <= next_ctrl[7:0];
            end
            if (wr_trig) begin
                trig_cfg <= next_trig[3:0];
            end
            if (wr_torch) begin
                torch_lvl <= next_torch[15:0];
            end
            if (wr_flash) begin
                flash_lvl <= next_flash[15:0];
            end
            if (wr_ser) begin
                ser_tx <= next_ser[8:0];
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    wire ar_take = s_axi_arvalid && s_axi_arready;

    wire [31:0] stat_word = {16'h0000, rx_byte, 3'h0, vdd_ok, vin_ok, mode};
    wire rd_ctrl  = (s_axi_araddr == fdm_pkg::ADDR_CTRL);
    wire rd_trig  = (s_axi_araddr == fdm_pkg::ADDR_TRIG_CFG);
    wire rd_torch = (s_axi_araddr == fdm_pkg::ADDR_TORCH_LVL);
    wire rd_flash = (s_axi_araddr == fdm_pkg::ADDR_FLASH_LVL);
    wire rd_stat  = (s_axi_araddr == fdm_pkg::ADDR_STATUS);
    wire rd_ser   = (s_axi_araddr == fdm_pkg::ADDR_SER_TX);
    wire rd_hit   = rd_ctrl || rd_trig || rd_torch || rd_flash || rd_stat || rd_ser;

    wire [31:0] rd_word =
        rd_ctrl  ? {24'h00_0000, ctrl} :
        rd_trig  ? {28'h000_0000, trig_cfg} :
        rd_torch ? {16'h0000, torch_lvl} :
        rd_flash ? {16'h0000, flash_lvl} :
        rd_stat  ? stat_word :
        rd_ser   ? {23'h00_0000, ser_tx} : 32'h0000_0000;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= fdm_pkg::RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? fdm_pkg::RESP_OKAY : fdm_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Regulator requests
    // ------------------------------------------------------------
    // A trigger with no function assigned is ignored in every mode.
    wire [1:0] trig_a_fn = trig_cfg[fdm_pkg::TRIG_A_FN +: 2];
    wire [1:0] trig_b_fn = trig_cfg[fdm_pkg::TRIG_B_FN +: 2];
    wire trig_torch = (trig_a && trig_a_fn == fdm_pkg::TRIG_TORCH) ||
                      (trig_b && trig_b_fn == fdm_pkg::TRIG_TORCH);
    wire trig_flash = (trig_a && trig_a_fn == fdm_pkg::TRIG_FLASH) ||
                      (trig_b && trig_b_fn == fdm_pkg::TRIG_FLASH);

    // A trigger acts on every regulator whose software enable is set.
    wire [1:0] sw_torch = ctrl[fdm_pkg::CTRL_TORCH +: 2];
    wire [1:0] sw_flash = ctrl[fdm_pkg::CTRL_FLASH +: 2];
    wire [1:0] sel_mask = sw_torch | sw_flash;
    wire [1:0] torch_req = sw_torch | (trig_torch ? sel_mask : 2'b00);
    wire [1:0] flash_req = sw_flash | (trig_flash ? sel_mask : 2'b00);

    wire any_flash = |flash_req;
    wire any_torch = |(torch_req & ~flash_req);
    wire any_req   = any_flash || any_torch;
    wire boost_req = ctrl[fdm_pkg::CTRL_BOOST_EN];

    // ------------------------------------------------------------
    // Mode sequencer
    // ------------------------------------------------------------
    fdm_pkg::fdm_mode_t next_mode;

    always_comb begin
        next_mode = mode;
        unique case (mode)
            fdm_pkg::FDM_SHUTDOWN: begin
                next_mode = fdm_pkg::FDM_STANDBY;
            end
            fdm_pkg::FDM_STANDBY: begin
                if (vin_ok && (any_req || boost_req)) begin
                    next_mode = fdm_pkg::FDM_ACTIVE;
                end
            end
            fdm_pkg::FDM_ACTIVE: begin
                if (!vin_ok || !(boost_req || any_req)) begin
                    next_mode = fdm_pkg::FDM_STANDBY;
                end else if (any_flash) begin
                    next_mode = fdm_pkg::FDM_FLASH;
                end else if (any_torch) begin
                    next_mode = fdm_pkg::FDM_TORCH;
                end
            end
            fdm_pkg::FDM_TORCH: begin
                if (!vin_ok) begin
                    next_mode = fdm_pkg::FDM_STANDBY;
                end else if (any_flash) begin
                    next_mode = fdm_pkg::FDM_FLASH;
                end else if (!any_torch) begin
                    next_mode = fdm_pkg::FDM_ACTIVE;
                end
            end
            fdm_pkg::FDM_FLASH: begin
                if (!vin_ok) begin
                    next_mode = fdm_pkg::FDM_STANDBY;
                end else if (!any_flash) begin
                    next_mode = any_torch ? fdm_pkg::FDM_TORCH : fdm_pkg::FDM_ACTIVE;
                end
            end
            default: begin
                next_mode = fdm_pkg::FDM_SHUTDOWN;
            end
        endcase
    end

    // Shutdown wins over every other transition.
    always_ff @(posedge mclk_i) begin
        if (regs_clr) begin
            mode <= fdm_pkg::FDM_SHUTDOWN;
        end else begin
            mode <= next_mode;
        end
    end

    // ------------------------------------------------------------
    // Power stage outputs
    // ------------------------------------------------------------
    wire in_led_mode = (mode == fdm_pkg::FDM_TORCH) || (mode == fdm_pkg::FDM_FLASH);
    wire in_flash    = (mode == fdm_pkg::FDM_FLASH);
    wire [1:0] led_on    = in_led_mode ? (flash_req & {2{in_flash}}) | torch_req
                                       : 2'b00;
    wire [1:0] led_flash = flash_req & {2{in_flash}};

    always_ff @(posedge mclk_i) begin
        if (regs_clr) begin
            boost_en_o             <= 1'b0;
            boost_mode_select_o    <= 2'b00;
            led_output_one_en_o    <= 1'b0;
            led_output_two_en_o    <= 1'b0;
            led_output_one_flash_o <= 1'b0;
            led_output_two_flash_o <= 1'b0;
            led_output_one_level_o <= 8'h00;
            led_output_two_level_o <= 8'h00;
        end else begin
            boost_en_o             <= (mode == fdm_pkg::FDM_ACTIVE) || in_led_mode;
            boost_mode_select_o    <= ctrl[fdm_pkg::CTRL_BOOST_MODE +: 2];
            led_output_one_en_o    <= led_on[0];
            led_output_two_en_o    <= led_on[1];
            led_output_one_flash_o <= led_on[0] && led_flash[0];
            led_output_two_flash_o <= led_on[1] && led_flash[1];
            led_output_one_level_o <= !led_on[0] ? 8'h00 :
                                      led_flash[0] ? flash_lvl[7:0] : torch_lvl[7:0];
            led_output_two_level_o <= !led_on[1] ? 8'h00 :
                                      led_flash[1] ? flash_lvl[15:8] : torch_lvl[15:8];
        end
    end

    assign mode_o = mode;

    // ------------------------------------------------------------
    // Serial data line
    // ------------------------------------------------------------
    // Bits are counted freely; the counter has no framing, so software
    // reads the received byte only after a known multiple of eight clocks.
    // The edge detector rests high like the idle line, so a reset makes no false rise.
    logic       scl_q;
    logic [2:0] bit_cnt;
    logic [7:0] rx_shift;

    wire scl_rise = scl_s && !scl_q;
    wire scl_fall = !scl_s && scl_q;
    wire [2:0] tx_idx = 3'd7 - bit_cnt;

    always_ff @(posedge mclk_i) begin
        if (regs_clr) begin
            scl_q    <= 1'b1;
            bit_cnt  <= 3'd0;
            rx_shift <= 8'h00;
            rx_byte  <= 8'h00;
            sda_o    <= 1'b0;
            sda_oe_o <= 1'b0;
        end else begin
            scl_q <= scl_s;
            if (scl_rise) begin
                rx_shift <= {rx_shift[6:0], sda_s};
                bit_cnt  <= bit_cnt + 3'd1;
                if (bit_cnt == 3'd7) begin
                    rx_byte <= {rx_shift[6:0], sda_s};
                end
            end
            if (scl_fall) begin
                sda_o    <= ser_tx[tx_idx];
                sda_oe_o <= ser_tx[fdm_pkg::SER_DRIVE];
            end
        end
    end

endmodule

// ### tb/fdm_sva.sv
`timescale 1ns/1ps
module fdm_sva (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       logic_supply_ok_i,
    input  wire logic       input_supply_ok_i,
    input  wire logic       scl_i,
    input  wire logic       sda_o,
    input  wire logic       sda_oe_o,
    input  wire logic [2:0] mode_o,
    input  wire logic       boost_en_o,
    input  wire logic       led_output_one_en_o,
    input  wire logic       led_output_two_en_o,
    input  wire logic       led_output_one_flash_o,
    input  wire logic       led_output_two_flash_o
);
    // ----------------------------------------------------------
    // Mode, power stage and serial data line relations
    // ----------------------------------------------------------
    // Pins pass two sync flops and the state flop, so five low samples are ample.
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    shutdown_idle_a: assert property (mode_o == fdm_pkg::FDM_SHUTDOWN |=>
        !boost_en_o && !led_output_one_en_o && !led_output_two_en_o) else $error("power stage on in shutdown");
    supply_low_a: assert property (!logic_supply_ok_i [*5] |-> mode_o == fdm_pkg::FDM_SHUTDOWN)
        else $error("no shutdown on low logic supply");
    supply_up_a: assert property (logic_supply_ok_i [*5] |-> mode_o != fdm_pkg::FDM_SHUTDOWN)
        else $error("stuck in shutdown");
    vin_hold_a: assert property (!input_supply_ok_i [*5] |->
        mode_o inside {fdm_pkg::FDM_SHUTDOWN, fdm_pkg::FDM_STANDBY}) else $error("left standby on low input");
    active_off_a: assert property (mode_o == fdm_pkg::FDM_ACTIVE ##1 $stable(mode_o) |->
        boost_en_o && !led_output_one_en_o && !led_output_two_en_o) else $error("bad outputs in active");
    torch_out_a: assert property (mode_o == fdm_pkg::FDM_TORCH ##1 $stable(mode_o) |-> boost_en_o &&
        !led_output_one_flash_o && !led_output_two_flash_o && (led_output_one_en_o || led_output_two_en_o))
        else $error("bad outputs in torch");
    flash_out_a: assert property (mode_o == fdm_pkg::FDM_FLASH ##1 $stable(mode_o) |->
        boost_en_o && (led_output_one_flash_o || led_output_two_flash_o)) else $error("bad outputs in flash");
    flash_has_en_a: assert property ((led_output_one_flash_o |-> led_output_one_en_o) and
        (led_output_two_flash_o |-> led_output_two_en_o)) else $error("flash setting on idle regulator");
    legal_mode_a: assert property (mode_o <= 3'h4) else $error("illegal mode code");
    sda_on_fall_a: assert property (($changed(sda_o) && sda_oe_o) |-> !scl_i)
        else $error("data changed with serial clock high");
endmodule

bind fdm_mode_ctrl fdm_sva u_sva (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .logic_supply_ok_i(logic_supply_ok_i),
    .input_supply_ok_i(input_supply_ok_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .mode_o(mode_o),
    .boost_en_o(boost_en_o), .led_output_one_en_o(led_output_one_en_o), .led_output_two_en_o(led_output_two_en_o),
    .led_output_one_flash_o(led_output_one_flash_o), .led_output_two_flash_o(led_output_two_flash_o));

// ### tb/fdm_i2c_host.sv
`timescale 1ns/1ps
module fdm_i2c_host (
    output logic      scl_o,
    output wire logic sda_line_o,
    input  wire logic dev_sda_i,
    input  wire logic dev_oe_i
);
    // ----------------------------------------------------------
    // Two-wire host with a pulled-up data line
    // ----------------------------------------------------------
    logic host_low;

    assign sda_line_o = !host_low && !(dev_oe_i && !dev_sda_i);

    initial begin
        scl_o = 1'b1;
        host_low = 1'b0;
    end

    // The clock stands high between frames; the odd start offset keeps edges off the bench clock.
    task automatic frame(input logic [7:0] tx, input logic drive, output logic [7:0] rx);
        #1.3;
        host_low = 1'b1;
        #24;
        for (int i = 7; i >= 0; i--) begin
            scl_o = 1'b0;
            #8;
            host_low = drive && !tx[i];
            #16;
            scl_o = 1'b1;
            rx[i] = sda_line_o;
            #24;
        end
        host_low = 1'b0;
    endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
    logic        mclk_i = 1'b0, rst_n_i = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, logic_supply_ok_i = 1'b0, input_supply_ok_i = 1'b1;
    logic        trigger_input_a_i = 1'b0, trigger_input_b_i = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'hF;
    wire logic   scl_i, sda_i;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sda_o, sda_oe_o;
    logic        boost_en_o, led_output_one_en_o, led_output_two_en_o, led_output_one_flash_o, led_output_two_flash_o;
    logic [1:0]  s_axi_bresp, s_axi_rresp, boost_mode_select_o;
    logic [31:0] s_axi_rdata, d;
    logic [2:0]  mode_o;
    logic [7:0]  led_output_one_level_o, led_output_two_level_o, rx;
    logic [1:0]  r;
    int          failures = 0, n_tests = 0;
    wire logic [20:0] pwr = {boost_en_o, led_output_one_en_o, led_output_two_en_o, led_output_one_flash_o,
                             led_output_two_flash_o, led_output_one_level_o, led_output_two_level_o};
    logic [7:0]  cs [7] = '{8'h05, 8'h15, 8'h95, 8'h15, 8'h05, 8'h55, 8'h05};
    logic [2:0]  ms [7] = '{3'h2, 3'h3, 3'h4, 3'h3, 3'h2, 3'h4, 3'h2};
    logic [20:0] ps [7] = '{21'h10_0000, 21'h18_1100, 21'h1D_1144, 21'h18_1100, 21'h10_0000, 21'h1A_3300, 21'h10_0000};

    fdm_mode_ctrl dut (.mclk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .logic_supply_ok_i,
        .input_supply_ok_i, .trigger_input_a_i, .trigger_input_b_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .mode_o,
        .boost_en_o, .boost_mode_select_o, .led_output_one_en_o, .led_output_two_en_o, .led_output_one_flash_o,
        .led_output_two_flash_o, .led_output_one_level_o, .led_output_two_level_o);
    fdm_i2c_host u_host (.scl_o(scl_i), .sda_line_o(sda_i), .dev_sda_i(sda_o), .dev_oe_i(sda_oe_o));

    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end

    // ----------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            failures++;
            close_out();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] dv, input logic [1:0] er);
        int n;
        @(posedge mclk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= dv;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        bound(n, 50);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask

    task automatic put(input logic [7:0] a, input logic [31:0] dv);
        wr(a, dv, fdm_pkg::RESP_OKAY);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
        int n;
        @(posedge mclk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        bound(n, 50);
        dv = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // The mode may already match before a pin change has crossed the synchronisers, so settle first.
    task automatic wait_mode(input logic [2:0] m);
        int n;
        for (n = 0; n < 40; n++) begin
            @(posedge mclk_i);
            if (mode_o === m) break;
        end
        bound(n, 40);
        repeat (4) @(posedge mclk_i);
        chk(32'(mode_o), 32'(m));
    endtask

    task automatic step(input logic [7:0] c, input logic [2:0] m, input logic [20:0] p);
        put(fdm_pkg::ADDR_CTRL, 32'(c));
        wait_mode(m);
        chk(32'(pwr), 32'(p));
    endtask

    task automatic zeroes;
        for (int i = 0; i < 4; i++) begin
            rd(8'(4 * i), d, r);
            chk(d, 32'h0000_0000);
        end
    endtask

    // ----------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------
    initial begin
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        wait_mode(fdm_pkg::FDM_SHUTDOWN);
        chk(32'(pwr), 32'h0000_0000);
        logic_supply_ok_i <= 1'b1;
        wait_mode(fdm_pkg::FDM_STANDBY);
        zeroes();
        rd(8'h18, d, r);
        chk(32'(r), 32'(fdm_pkg::RESP_SLVERR));
        chk(d, 32'h0000_0000);
        wr(8'h1C, 32'h0000_0001, fdm_pkg::RESP_SLVERR);
        $display("power-up and register test done");
        put(fdm_pkg::ADDR_TORCH_LVL, 32'h0000_2211);
        put(fdm_pkg::ADDR_FLASH_LVL, 32'h0000_4433);
        for (int k = 0; k < 4; k++) begin
            put(fdm_pkg::ADDR_CTRL, 32'(1 + 2 * k));
            wait_mode(fdm_pkg::FDM_ACTIVE);
            chk(32'(boost_mode_select_o), 32'(k));
        end
        for (int i = 0; i < 7; i++) step(cs[i], ms[i], ps[i]);
        $display("mode walk test done");
        input_supply_ok_i <= 1'b0;
        wait_mode(fdm_pkg::FDM_STANDBY);
        put(fdm_pkg::ADDR_CTRL, 32'h0000_0015);
        wait_mode(fdm_pkg::FDM_STANDBY);
        input_supply_ok_i <= 1'b1;
        wait_mode(fdm_pkg::FDM_TORCH);
        step(8'h00, fdm_pkg::FDM_STANDBY, 21'h00_0000);
        $display("input supply test done");
        step(8'h11, fdm_pkg::FDM_TORCH, 21'h18_1100);
        for (int k = 0; k < 4; k++) begin
            put(fdm_pkg::ADDR_TRIG_CFG, 32'(k << 2));
            trigger_input_b_i <= 1'b1;
            wait_mode(k == 2 ? fdm_pkg::FDM_FLASH : fdm_pkg::FDM_TORCH);
            chk(32'(pwr), k == 2 ? 32'h001A_3300 : 32'h0018_1100);
            trigger_input_b_i <= 1'b0;
            wait_mode(fdm_pkg::FDM_TORCH);
        end
        put(fdm_pkg::ADDR_TRIG_CFG, 32'h0000_0002);
        trigger_input_a_i <= 1'b1;
        wait_mode(fdm_pkg::FDM_FLASH);
        trigger_input_a_i <= 1'b0;
        wait_mode(fdm_pkg::FDM_TORCH);
        $display("trigger test done");
        u_host.frame(8'h5A, 1'b1, rx);
        rd(fdm_pkg::ADDR_STATUS, d, r);
        chk(d, 32'h0000_5A1B);
        put(fdm_pkg::ADDR_SER_TX, 32'h0000_01A5);
        u_host.frame(8'hFF, 1'b0, rx);
        chk(32'(rx), 32'h0000_00A5);
        $display("serial test done");
        @(posedge mclk_i);
        logic_supply_ok_i <= 1'b0;
        wait_mode(fdm_pkg::FDM_SHUTDOWN);
        chk(32'(pwr), 32'h0000_0000);
        logic_supply_ok_i <= 1'b1;
        wait_mode(fdm_pkg::FDM_STANDBY);
        zeroes();
        $display("logic supply test done");
        close_out();
    end
endmodule
